/* common/rail_slew_pkg.sv */
// Purpose: shared constants and carriers for the rail setpoint and ramp control block
// Assumes: 100 MHz clock, 8-bit register access by subaddress
// Notes: times in ns, dwell times in 100 ps units, cycle counts derived from the clock period
package rail_slew_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [7:0] ADDR_RAMP_CONTROL = 8'h1a;
    localparam logic [7:0] ADDR_LINEAR_RAIL = 8'h1b;
    localparam logic [7:0] RAMP_CONTROL_RESET = 8'h06;
    localparam logic [7:0] LINEAR_RAIL_RESET = 8'h1f;
    localparam int BIT_TRIGGER = 7;
    localparam int BIT_TRIGGER_BYPASS = 6;
    localparam int RATE_MSB = 2;
    localparam int LIN_MSB = 5;
    localparam logic [2:0] RATE_IMMEDIATE = 3'h7;
    // dwell per step in units of 100 ps so 2.5 us is exact
    localparam int DWELL_160_PS100 = 1600000;
    localparam int DWELL_80_PS100 = 800000;
    localparam int DWELL_40_PS100 = 400000;
    localparam int DWELL_20_PS100 = 200000;
    localparam int DWELL_10_PS100 = 100000;
    localparam int DWELL_5_PS100 = 50000;
    localparam int DWELL_2P5_PS100 = 25000;
    localparam int CLK_PERIOD_PS100 = CLK_PERIOD_NS * 10;
    localparam int BLANK_TIME_NS = 5000000;
    localparam int BLANK_CYCLES = BLANK_TIME_NS / CLK_PERIOD_NS;
    localparam int DWELL_W = 15;
    localparam int BLANK_W = 20;
    // linear rail: 25 mV steps to code 1ah then 50 mV steps; mV units
    localparam int LIN_BASE_MV = 900;
    localparam int LIN_STEP_FINE_MV = 25;
    localparam int LIN_STEP_COARSE_MV = 50;
    localparam logic [5:0] LIN_KNEE_CODE = 6'h1a;

    typedef struct packed {
        logic we;
        logic re;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic [5:0] core_one;
        logic [5:0] core_two;
    } core_codes_s;
endpackage

/* hdl/ramp_stepper.sv */
// Purpose: steps one core buck setpoint code toward a target, one code per dwell
// Assumes: dwell_cycles stable during a ramp, zero means immediate
// Notes: busy drops on the cycle the output equals the target
`timescale 1ns/100ps
module ramp_stepper
    import rail_slew_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic [5:0] load_target,
    input wire logic [5:0] reset_code,
    input wire logic [DWELL_W-1:0] dwell_cycles,
    output logic [5:0] code_out,
    output logic busy
);
    logic [5:0] target_r, target_nxt, code_r, code_nxt;
    logic [DWELL_W-1:0] cnt_r, cnt_nxt;
    logic init_r, init_nxt;

    always_comb
    begin
        target_nxt = target_r;
        code_nxt = code_r;
        cnt_nxt = cnt_r;
        init_nxt = 1'b1;
        if (!init_r)
        begin
            // straps taken after reset release, not under the asynchronous reset
            target_nxt = reset_code;
            code_nxt = reset_code;
        end
        else if (load)
        begin
            target_nxt = load_target;
            cnt_nxt = '0;
        end
        else if (code_r != target_r)
        begin
            if (dwell_cycles == '0)
                code_nxt = target_r;
            else if (cnt_r >= dwell_cycles - DWELL_W'(1))
            begin
                cnt_nxt = '0;
                code_nxt = (target_r > code_r) ? code_r + 6'h01 : code_r - 6'h01;
            end
            else
                cnt_nxt = cnt_r + DWELL_W'(1);
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            target_r <= 6'h00;
            code_r <= 6'h00;
            cnt_r <= '0;
            init_r <= 1'b0;
        end
        else
        begin
            target_r <= target_nxt;
            code_r <= code_nxt;
            cnt_r <= cnt_nxt;
            init_r <= init_nxt;
        end
    end

    assign code_out = code_r;
    assign busy = init_r && (code_r != target_r);
endmodule

/* hdl/blank_timer.sv */
// Purpose: holds supervision blanking for a fixed window after a trigger
// Assumes: start is a one-cycle pulse on clk
// Notes: a new start restarts the full window
`timescale 1ns/100ps
module blank_timer
    import rail_slew_pkg::*;
#(
    parameter int unsigned BLANK_LEN = BLANK_CYCLES
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic start,
    output logic blank
);
    logic [BLANK_W-1:0] cnt_r, cnt_nxt;

    always_comb
    begin
        if (start)
            cnt_nxt = BLANK_W'(BLANK_LEN);
        else if (cnt_r != '0)
            cnt_nxt = cnt_r - BLANK_W'(1);
        else
            cnt_nxt = cnt_r;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

    assign blank = (cnt_r != '0);
endmodule

/* hdl/rail_setpoint_slew_control.sv */
// Purpose: ramp-control and linear-rail setpoint registers with core buck ramp engine
// Assumes: register strobes come from the management bus decoder on clk; unlock from password logic
// Notes: stored core setpoints come from the rails' own registers via core_store and store strobes
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - ramp-control register sits at subaddress 0x1A, resets to 0x06
// - programmed ramp rate affects only the two core buck rails
// - writing 1 to bit 7 ramps both core rails to stored setpoints
// - trigger bit clears itself when the started transition completes
// - bypass bit 6 set: every core setpoint update ramps at once
// - rate codes 0,1,2 give 160, 80, 40 us per step
// - codes 3 to 6 give 20, 10, 5, 2.5 us; 6 is reset
// - rate code 7 applies the new setpoint immediately
// - ramp moves one setpoint code per dwell interval
// - linear-rail register at 0x1B, reset 0x1F, writes need unlock
// - each unlocked linear-rail write blanks over/undervoltage monitoring for 5 ms
// - linear code maps 0.900 V in 25 mV steps, then 50 mV
module rail_setpoint_slew_control
    import rail_slew_pkg::*;
#(
    parameter int unsigned BLANK_LEN = BLANK_CYCLES
)
(
    input wire logic clk,
    input wire logic reset_n,
    input rail_slew_pkg::reg_req_s req,
    input wire logic write_unlocked,
    input rail_slew_pkg::core_codes_s core_store,
    input rail_slew_pkg::core_codes_s core_reset,
    input wire logic core_store_update,
    output logic [7:0] rdata,
    output logic rdata_valid,
    output rail_slew_pkg::core_codes_s core_active,
    output logic [5:0] linear_rail_code,
    output logic [11:0] linear_rail_mv,
    output logic supervision_blank,
    output logic ramp_busy
);
    import rail_slew_pkg::*;

    //////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic [DWELL_W-1:0] dwell_of(input logic [2:0] code);
        int ps;
        ps = 0;
        case (code)
            3'h0: ps = DWELL_160_PS100;
            3'h1: ps = DWELL_80_PS100;
            3'h2: ps = DWELL_40_PS100;
            3'h3: ps = DWELL_20_PS100;
            3'h4: ps = DWELL_10_PS100;
            3'h5: ps = DWELL_5_PS100;
            3'h6: ps = DWELL_2P5_PS100;
            default: ps = 0;
        endcase
        return DWELL_W'(ps / CLK_PERIOD_PS100);
    endfunction

    function automatic logic [11:0] lin_mv(input logic [5:0] code);
        int mv;
        mv = 0;
        if (code <= LIN_KNEE_CODE)
            mv = LIN_BASE_MV + LIN_STEP_FINE_MV * int'(code);
        else
            mv = LIN_BASE_MV + LIN_STEP_FINE_MV * int'(LIN_KNEE_CODE)
                + LIN_STEP_COARSE_MV * (int'(code) - int'(LIN_KNEE_CODE));
        return 12'(mv);
    endfunction

    //////////////////////////////////////////////////////////////////////////////
    // registers

    logic trigger_r, trigger_nxt;
    logic trigger_bypass_r, trigger_bypass_nxt;
    logic [2:0] rate_r, rate_nxt;
    logic [5:0] lin_r, lin_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic launch_r, launch_nxt;
    logic wr_ramp, wr_lin, launch;
    logic [1:0] busy_v;
    logic [DWELL_W-1:0] dwell;
    logic [7:0] ramp_view;
    logic [5:0] code_one, code_two;

    assign wr_ramp = req.we && (req.addr == ADDR_RAMP_CONTROL);
    assign wr_lin = req.we && (req.addr == ADDR_LINEAR_RAIL) && write_unlocked;
    assign ramp_view = {trigger_r, trigger_bypass_r, 3'b000, rate_r};

    // the trigger or a bypassed store hands new targets to the steppers
    assign launch = (wr_ramp && req.wdata[BIT_TRIGGER])
        || (trigger_bypass_r && core_store_update);

    always_comb
    begin
        trigger_nxt = trigger_r;
        trigger_bypass_nxt = trigger_bypass_r;
        rate_nxt = rate_r;
        lin_nxt = lin_r;
        launch_nxt = launch;
        // launch_r masks the first cycle after a launch; a trigger write sets it again below
        if (trigger_r && !launch_r && busy_v == 2'b00)
            trigger_nxt = 1'b0;
        if (wr_ramp)
        begin
            trigger_bypass_nxt = req.wdata[BIT_TRIGGER_BYPASS];
            rate_nxt = req.wdata[RATE_MSB:0];
            if (req.wdata[BIT_TRIGGER])
                trigger_nxt = 1'b1;
        end
        if (wr_lin)
            lin_nxt = req.wdata[LIN_MSB:0];
        rvalid_nxt = req.re;
        rdata_nxt = 8'h00;
        if (req.re)
        begin
            if (req.addr == ADDR_RAMP_CONTROL)
                rdata_nxt = ramp_view;
            else if (req.addr == ADDR_LINEAR_RAIL)
                rdata_nxt = {2'b00, lin_r};
            else
                rdata_nxt = 8'h00;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            trigger_r <= RAMP_CONTROL_RESET[BIT_TRIGGER];
            trigger_bypass_r <= RAMP_CONTROL_RESET[BIT_TRIGGER_BYPASS];
            rate_r <= RAMP_CONTROL_RESET[RATE_MSB:0];
            lin_r <= LINEAR_RAIL_RESET[LIN_MSB:0];
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
            launch_r <= 1'b0;
        end
        else
        begin
            trigger_r <= trigger_nxt;
            trigger_bypass_r <= trigger_bypass_nxt;
            rate_r <= rate_nxt;
            lin_r <= lin_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            launch_r <= launch_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // ramp engines, core buck rails only

    assign dwell = dwell_of(rate_r);

    ramp_stepper u_step_one (
        .clk(clk),
        .reset_n(reset_n),
        .load(launch),
        .load_target(core_store.core_one),
        .reset_code(core_reset.core_one),
        .dwell_cycles(dwell),
        .code_out(code_one),
        .busy(busy_v[0])
    );

    ramp_stepper u_step_two (
        .clk(clk),
        .reset_n(reset_n),
        .load(launch),
        .load_target(core_store.core_two),
        .reset_code(core_reset.core_two),
        .dwell_cycles(dwell),
        .code_out(code_two),
        .busy(busy_v[1])
    );

    blank_timer #(
        .BLANK_LEN(BLANK_LEN)
    ) u_blank (
        .clk(clk),
        .reset_n(reset_n),
        .start(wr_lin),
        .blank(supervision_blank)
    );

    // linear rail follows its code directly; rate setting never touches it
    assign core_active = '{core_one: code_one, core_two: code_two};
    assign linear_rail_code = lin_r;
    assign linear_rail_mv = lin_mv(lin_r);
    assign rdata = rdata_r;
    assign rdata_valid = rvalid_r;
    assign ramp_busy = |busy_v;

    //////////////////////////////////////////////////////////////////////////////
    // checks

    property p_trig_set;
        @(posedge clk) disable iff (!reset_n)
        (wr_ramp && req.wdata[BIT_TRIGGER]) |=> trigger_r;
    endproperty
    a_trig_set: assert property (p_trig_set) else $error("trigger write did not set bit");

    property p_trig_clear;
        @(posedge clk) disable iff (!reset_n)
        (trigger_r && !launch_r && !ramp_busy && !launch) |=> !trigger_r;
    endproperty
    a_trig_clear: assert property (p_trig_clear) else $error("trigger not cleared at completion");

    property p_bypass;
        @(posedge clk) disable iff (!reset_n)
        (trigger_bypass_r && core_store_update) |=> (ramp_busy || core_active == $past(core_store));
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypassed update did not launch");

    property p_hold;
        @(posedge clk) disable iff (!reset_n)
        (!launch && !ramp_busy && $past(reset_n)) |=> $stable(core_active);
    endproperty
    a_hold: assert property (p_hold) else $error("core target moved without launch");

    property p_immediate;
        @(posedge clk) disable iff (!reset_n)
        (launch && rate_r == RATE_IMMEDIATE && !wr_ramp) |=> ##1 (core_active == $past(core_store, 2));
    endproperty
    a_immediate: assert property (p_immediate) else $error("immediate rate did not settle");

    property p_one_step;
        @(posedge clk) disable iff (!reset_n)
        $past(reset_n) |=> (core_active.core_one - $past(core_active.core_one) inside {6'h00, 6'h01, 6'h3f})
            || (rate_r == RATE_IMMEDIATE) || ($past(rate_r) == RATE_IMMEDIATE);
    endproperty
    a_one_step: assert property (p_one_step) else $error("ramp moved more than one code");

    property p_blank;
        @(posedge clk) disable iff (!reset_n)
        wr_lin |=> supervision_blank [*8];
    endproperty
    a_blank: assert property (p_blank) else $error("no blanking after linear write");

    property p_locked;
        @(posedge clk) disable iff (!reset_n)
        (req.we && req.addr == ADDR_LINEAR_RAIL && !write_unlocked) |=> $stable(lin_r);
    endproperty
    a_locked: assert property (p_locked) else $error("locked linear write changed value");

    property p_reserved;
        @(posedge clk) disable iff (!reset_n)
        rdata_valid |-> (rdata[5:3] == 3'b000 || $past(req.addr) != ADDR_RAMP_CONTROL);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");
endmodule

/* sim/host_model.sv */
// Purpose: management bus master and core setpoint register source facing the block
// Assumes: one-cycle strobes, all changes made at the falling edge of clk
// Notes: core_store holds its last value, like the rails' own setpoint registers
`timescale 1ns/100ps
module host_model
(
    input wire logic clk,
    output rail_slew_pkg::reg_req_s req,
    output rail_slew_pkg::core_codes_s core_store,
    output logic core_store_update,
    input wire logic [7:0] rdata,
    input wire logic rdata_valid
);
    import rail_slew_pkg::*;

    initial
    begin
        req = '0;
        core_store = '0;
        core_store_update = 1'b0;
    end

    //////////////////////////////////////////////////////////////////////////////
    // one strobe per access; release waits a full cycle so the taking edge sees it
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req = '0;
    endtask

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk);
        req = '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        req = '0;
        v = rdata_valid;
        d = rdata;
    endtask

    // light-load skip lives in the rails' own registers, not driven from here
    task automatic load_core(input core_codes_s c);
        @(negedge clk);
        core_store = c;
        core_store_update = 1'b1;
        @(negedge clk);
        core_store_update = 1'b0;
    endtask
endmodule

/* sim/test_rail_setpoint_slew_control.sv */
// Purpose: self-checking bench for the ramp-control and linear-rail registers
// Assumes: short blanking window in sim, dwell counts as the design's cycle table
// Notes: ramp timing judged within a few cycles since the launch edge is not exposed
`timescale 1ns/100ps
module test_rail_setpoint_slew_control;
    import rail_slew_pkg::*;
    localparam int unsigned BLANK_SIM = 20;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic write_unlocked = 1'b0;
    reg_req_s req;
    core_codes_s core_store;
    core_codes_s core_reset = {6'h10, 6'h20};
    core_codes_s core_active;
    logic core_store_update;
    logic [7:0] rdata;
    logic rdata_valid;
    logic [5:0] linear_rail_code;
    logic [11:0] linear_rail_mv;
    logic supervision_blank;
    logic ramp_busy;
    int num_errors = 0;
    int n_tests = 0;
    int dwell_tab [8] = '{16000, 8000, 4000, 2000, 1000, 500, 250, 0};

    always #5 clk = ~clk;

    host_model host (.clk(clk), .req(req), .core_store(core_store), .core_store_update(core_store_update),
        .rdata(rdata), .rdata_valid(rdata_valid));

    rail_setpoint_slew_control #(.BLANK_LEN(BLANK_SIM)) DUT (.clk(clk), .reset_n(reset_n), .req(req),
        .write_unlocked(write_unlocked), .core_store(core_store), .core_reset(core_reset),
        .core_store_update(core_store_update), .rdata(rdata), .rdata_valid(rdata_valid),
        .core_active(core_active), .linear_rail_code(linear_rail_code), .linear_rail_mv(linear_rail_mv),
        .supervision_blank(supervision_blank), .ramp_busy(ramp_busy));

    //////////////////////////////////////////////////////////////////////////////
    task automatic check_val(input logic [11:0] got, input logic [11:0] exp, input string msg);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic check_win(input int got, input int lo, input int hi, input string msg);
        n_tests++;
        if (got < lo || got > hi)
        begin
            num_errors++;
            $display("BAD %0t %s took %0d", $time, msg, got);
        end
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        host.read_reg(a, d, v);
        check_val({11'h000, v}, 12'h001, "read valid");
        check_val({4'h0, d}, {4'h0, exp}, "read data");
    endtask

    task automatic bump(input core_codes_s s, input logic [5:0] k, output core_codes_s t);
        t = {s.core_one + k, s.core_two + k};
    endtask

    //////////////////////////////////////////////////////////////////////////////
    task automatic test_reset_values;
        rd_check(ADDR_RAMP_CONTROL, 8'h06);
        rd_check(ADDR_LINEAR_RAIL, 8'h1f);
        rd_check(8'h1c, 8'h00);
        check_val(linear_rail_mv, 12'h708, "reset mv");
        check_val(core_active, {6'h10, 6'h20}, "core after reset");
    endtask

    task automatic test_linear;
        host.write_reg(ADDR_LINEAR_RAIL, 8'h05);
        rd_check(ADDR_LINEAR_RAIL, 8'h1f);
        check_val(supervision_blank, 1'b0, "locked blank");
        @(negedge clk);
        write_unlocked = 1'b1;
        host.write_reg(ADDR_LINEAR_RAIL, 8'hc0);
        check_val(linear_rail_mv, 12'h384, "mv code 0");
        rd_check(ADDR_LINEAR_RAIL, 8'h00);
        check_val(supervision_blank, 1'b1, "blank on");
        repeat (BLANK_SIM - 5) @(negedge clk);
        check_val(supervision_blank, 1'b1, "blank held");
        repeat (8) @(negedge clk);
        check_val(supervision_blank, 1'b0, "blank off");
        host.write_reg(ADDR_LINEAR_RAIL, 8'h1a);
        check_val(linear_rail_mv, 12'h60e, "mv knee");
        host.write_reg(ADDR_LINEAR_RAIL, 8'hff);
        check_val(linear_rail_mv, 12'hd48, "mv top");
        check_val(linear_rail_code, 6'h3f, "code top");
        rd_check(ADDR_RAMP_CONTROL, 8'h06);
    endtask

    // every rate code once; 160 us dwell is long but still well inside the run limit
    task automatic test_rates;
        core_codes_s s;
        core_codes_s t;
        int n;
        for (int c = 0; c < 8; c++)
        begin
            s = core_active;
            bump(s, 6'h01, t);
            host.load_core(t);
            check_val(core_active, s, "stored only");
            host.write_reg(ADDR_RAMP_CONTROL, {5'h10, c[2:0]});
            n = 0;
            while (core_active === s && n < dwell_tab[c] + 20)
            begin
                @(negedge clk);
                n++;
            end
            check_win(n, (c == 7) ? 0 : dwell_tab[c] - 3, (c == 7) ? 2 : dwell_tab[c] + 3, "dwell");
            check_val(core_active, t, "both rails");
            repeat (4) @(negedge clk);
        end
    endtask

    task automatic test_two_step;
        core_codes_s s;
        core_codes_s t;
        host.write_reg(ADDR_RAMP_CONTROL, 8'h3e);
        rd_check(ADDR_RAMP_CONTROL, 8'h06);
        s = core_active;
        bump(s, 6'h02, t);
        host.load_core(t);
        host.write_reg(ADDR_RAMP_CONTROL, 8'h86);
        rd_check(ADDR_RAMP_CONTROL, 8'h86);
        check_val(ramp_busy, 1'b1, "busy during ramp");
        repeat (254) @(negedge clk);
        bump(s, 6'h01, s);
        check_val(core_active, s, "one step");
        repeat (252) @(negedge clk);
        check_val(core_active, t, "two steps");
        repeat (5) @(negedge clk);
        rd_check(ADDR_RAMP_CONTROL, 8'h06);
        check_val(ramp_busy, 1'b0, "idle");
    endtask

    task automatic test_bypass;
        core_codes_s s;
        core_codes_s t;
        s = core_active;
        bump(s, 6'h3f, t);
        host.write_reg(ADDR_RAMP_CONTROL, 8'h47);
        host.load_core(t);
        repeat (3) @(negedge clk);
        check_val(core_active, t, "bypass launch");
        host.write_reg(ADDR_RAMP_CONTROL, 8'h07);
        host.load_core(s);
        repeat (10) @(negedge clk);
        check_val(core_active, t, "trigger needed");
        host.write_reg(ADDR_RAMP_CONTROL, 8'h07);
        repeat (5) @(negedge clk);
        check_val(core_active, t, "zero write");
        host.write_reg(ADDR_RAMP_CONTROL, 8'h87);
        repeat (3) @(negedge clk);
        check_val(core_active, s, "trigger launch");
    endtask

    //////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (num_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // the rate sweep needs about 32000 cycles; allow nearly twice that
    initial
    begin
        #600000;
        num_errors++;
        complete_run;
    end

    initial
    begin
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        test_reset_values;
        test_linear;
        test_rates;
        test_two_step;
        test_bypass;
        complete_run;
    end
endmodule
